/* rtl/tmpow_pkg.sv */
// Constants, register layout and carrier types for the one-shot timer with pin routing and wake-up.
// Assumes a single 100 MHz clock and an APB master with 32-bit data.
package tmpow_pkg;
   // Register byte addresses
   localparam logic [7:0] ADDR_COUNT = 8'h00;
   localparam logic [7:0] ADDR_COMPARE = 8'h04;
   localparam logic [7:0] ADDR_PCTRL = 8'h08;
   localparam logic [7:0] ADDR_SCTRL = 8'h0c;
   localparam logic [7:0] ADDR_IRQFL = 8'h10;
   localparam logic [7:0] ADDR_WAKEFL = 8'h14;
   localparam logic [7:0] ADDR_LPWAKE = 8'h18;

   // Primary control fields
   localparam int PC_MODE_LSB = 0;
   localparam int PC_EN_BIT = 4;
   localparam int PC_POL_BIT = 5;
   localparam int PC_PRES_LSB = 16;
   // Secondary control fields
   localparam int SC_OUTEN_BIT = 0;
   localparam int SC_INVEN_BIT = 1;
   localparam int SC_IRQEN_BIT = 2;
   localparam int SC_WAKEEN_BIT = 3;
   localparam int SC_CLKEN_BIT = 4;
   localparam int SC_CLKRDY_BIT = 5;
   localparam int SC_PININ_BIT = 6;
   // Flag fields
   localparam int FL_FLAG_BIT = 0;
   localparam int LP_ENABLE_BIT = 1;

   // Mode encodings
   localparam int MODE_W = 4;
   localparam logic [3:0] MODE_ONESHOT = 4'h0;
   localparam logic [3:0] MODE_CONTINUOUS = 4'h1;
   localparam logic [3:0] MODE_COUNTER = 4'h2;
   localparam logic [3:0] MODE_PWM = 4'h3;
   localparam logic [3:0] MODE_CAPTURE = 4'h4;
   localparam logic [3:0] MODE_COMPARE = 4'h5;
   localparam logic [3:0] MODE_GATED = 4'h6;
   localparam logic [3:0] MODE_CAPCMP = 4'h7;
   localparam logic [3:0] MODE_DUALEDGE = 4'h8;
   localparam logic [3:0] MODE_INACTGATED = 4'he;

   // Prescaler: field holds divide ratio minus one, so 1..4096
   localparam int PRES_W = 12;
   localparam logic [11:0] PRES_RESET = 12'h000;

   // Count values
   localparam logic [31:0] COUNT_RESET = 32'h00000000;
   localparam logic [31:0] COUNT_RELOAD = 32'h00000001;
   localparam logic [31:0] COMPARE_RESET = 32'hffffffff;

   // Instance kinds
   localparam logic [1:0] KIND_FULL_COMP = 2'h0;
   localparam logic [1:0] KIND_FULL = 2'h1;
   localparam logic [1:0] KIND_LOWPOWER = 2'h2;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } tmpow_apb_req_t;

   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } tmpow_apb_rsp_t;

   typedef struct packed {
      logic pinASignal;
      logic pinAOe;
      logic pinAInvertedSignal;
      logic pinAInvertedOe;
      logic pinBSignal;
      logic pinBOe;
      logic pinBInvertedSignal;
      logic pinBInvertedOe;
   } tmpow_pin_out_t;

   typedef struct packed {
      logic pinASignal;
      logic pinBSignal;
   } tmpow_pin_in_t;
endpackage : tmpow_pkg

/* rtl/tmpow_prescaler.sv */
// Prescaler that turns the timer clock into a one-cycle counter-clock enable.
// Assumes the divide field only changes while the timer is disabled.
`timescale 1ns/10ps
module tmpow_prescaler
   import tmpow_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Control
   input wire logic enable,
   input wire logic [PRES_W-1:0] divideMinusOne,
   // Counter clock enable
   output logic tick
);
   typedef struct packed {
      logic [PRES_W-1:0] count;
      logic tick;
   } tmpow_pres_state_t;

   tmpow_pres_state_t state;
   tmpow_pres_state_t next_state;

   always_comb begin
      next_state = state;
      next_state.tick = 1'b0;
      if (!enable) begin
         next_state.count = '0;
      // A divide field lowered below the running count must not stall ticks until the count wraps
      end else if (state.count >= divideMinusOne) begin
         next_state.count = '0;
         next_state.tick = 1'b1;
      end else begin
         next_state.count = state.count + 12'h001;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign tick = state.tick;
endmodule : tmpow_prescaler

/* rtl/tmpow_timer.sv */
// TimerA of one timer instance: APB registers, one-shot counting, pin direction and wake-up.
// Assumes one synchronous clock and pins already synchronised by the pad logic.
// Operation
// - Mode field codes: one-shot 0 ... dual-edge 8, inactive-gated 14; others reserved.
// - Modes 0, 1, 3, 5 use the timer pin as an output.
// - Modes 2, 4, 6, 7, 8, 14 use the timer pin as an input.
// - Only the first two full timers have complementary outputs.
// - Low-power instance has TimerA only, routed through its B-side pin.
// - Low-power timer keeps counting while system clock stops; wake re-enables it.
// - Wake-up events issue only when the wake enable bit is set.
// - A readable wake flag tells whether this timer caused the wake-up.
// - Any low-power event sets interrupt flag and low-power wake status bit.
// - One-shot counts up to compare then disables itself.
// - Period ends on the counter tick after count equals compare.
// - End of one-shot loads count with one and clears enable.
// - Output goes active for exactly one counter clock at period end.
// - End of one-shot sets the interrupt flag.
// - Period equals compare minus initial count plus one counter clocks.
// - Reset clears count to zero; reloads set it to one.
// - Software may write an initial count that affects only the first period.
// - Counter clock is source clock divided by a prescaler from 1 to 4096.
//
// Local design decisions: the register offsets and register access over APB.
`timescale 1ns/10ps
module tmpow_timer
   import tmpow_pkg::*;
#(
   parameter logic [1:0] INSTANCE_KIND = KIND_FULL_COMP
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // APB slave
   input wire tmpow_apb_req_t apbReq,
   output tmpow_apb_rsp_t apbRsp,
   // Timer pins
   input wire tmpow_pin_in_t pinIn,
   output tmpow_pin_out_t pinOut,
   // Clock control
   input wire logic sysClockStopped,
   output logic wakeClockRequest
);
   localparam logic IS_LP = (INSTANCE_KIND == KIND_LOWPOWER);
   localparam logic HAS_COMP = (INSTANCE_KIND == KIND_FULL_COMP);

   typedef struct packed {
      logic [31:0] count;
      logic [31:0] compare;
      logic [MODE_W-1:0] mode;
      logic en;
      logic pol;
      logic [PRES_W-1:0] pres;
      logic outEnable;
      logic invOutEnable;
      logic irqEnable;
      logic wakeEnable;
      logic clkEnable;
      logic clkReady;
      logic pinInput;
      logic irqFlag;
      logic wakeFlag;
      logic lpWakeStatus;
      logic lpWakeEnable;
      logic pulse;
      logic timerOut;
      logic [31:0] prdata;
   } tmpow_state_t;

   tmpow_state_t state;
   tmpow_state_t next_state;
   logic tick;
   logic mapped;
   logic setupPhase;
   logic writeAccess;
   logic outputMode;
   logic inputMode;
   logic running;
   logic periodEnd;
   logic [31:0] readValue;
   logic [7:0] addr;

   tmpow_prescaler prescaler (
      .clk(clk),
      .reset(reset),
      .enable(state.clkEnable),
      .divideMinusOne(state.pres),
      .tick(tick)
   );

   assign addr = apbReq.paddr;
   assign mapped = (addr == ADDR_COUNT) || (addr == ADDR_COMPARE) || (addr == ADDR_PCTRL) ||
                   (addr == ADDR_SCTRL) || (addr == ADDR_IRQFL) || (addr == ADDR_WAKEFL) ||
                   (addr == ADDR_LPWAKE);
   assign setupPhase = apbReq.psel && !apbReq.penable;
   assign writeAccess = apbReq.psel && apbReq.penable && apbReq.pwrite && mapped;

   // Pin direction by mode; reserved codes leave the pin undriven and ignored
   always_comb begin
      outputMode = 1'b0;
      inputMode = 1'b0;
      unique case (state.mode)
         MODE_ONESHOT, MODE_CONTINUOUS, MODE_PWM, MODE_COMPARE: outputMode = 1'b1;
         MODE_COUNTER, MODE_CAPTURE, MODE_GATED, MODE_CAPCMP, MODE_DUALEDGE,
         MODE_INACTGATED: inputMode = 1'b1;
         default: begin
            outputMode = 1'b0;
            inputMode = 1'b0;
         end
      endcase
   end

   // Counting never looks at the system clock state, so a low-power instance runs on while it is stopped
   assign running = state.en && state.clkReady && (state.mode == MODE_ONESHOT);
   assign periodEnd = tick && running && (state.count == state.compare);

   always_comb begin
      readValue = 32'h00000000;
      unique case (addr)
         ADDR_COUNT: readValue = state.count;
         ADDR_COMPARE: readValue = state.compare;
         ADDR_PCTRL: begin
            readValue[PC_MODE_LSB +: MODE_W] = state.mode;
            readValue[PC_EN_BIT] = state.en;
            readValue[PC_POL_BIT] = state.pol;
            readValue[PC_PRES_LSB +: PRES_W] = state.pres;
         end
         ADDR_SCTRL: begin
            readValue[SC_OUTEN_BIT] = state.outEnable;
            readValue[SC_INVEN_BIT] = state.invOutEnable;
            readValue[SC_IRQEN_BIT] = state.irqEnable;
            readValue[SC_WAKEEN_BIT] = state.wakeEnable;
            readValue[SC_CLKEN_BIT] = state.clkEnable;
            readValue[SC_CLKRDY_BIT] = state.clkReady;
            readValue[SC_PININ_BIT] = state.pinInput;
         end
         ADDR_IRQFL: readValue[FL_FLAG_BIT] = state.irqFlag;
         ADDR_WAKEFL: readValue[FL_FLAG_BIT] = state.wakeFlag;
         ADDR_LPWAKE: begin
            readValue[FL_FLAG_BIT] = state.lpWakeStatus;
            readValue[LP_ENABLE_BIT] = state.lpWakeEnable;
         end
         default: readValue = 32'h00000000;
      endcase
   end

   always_comb begin
      logic clearIrq;
      logic clearWake;
      logic clearLp;
      clearIrq = 1'b0;
      clearWake = 1'b0;
      clearLp = 1'b0;
      next_state = state;
      if (setupPhase) begin
         next_state.prdata = readValue;
      end
      if (writeAccess) begin
         unique case (addr)
            ADDR_COUNT: next_state.count = apbReq.pwdata;
            ADDR_COMPARE: next_state.compare = apbReq.pwdata;
            ADDR_PCTRL: begin
               next_state.mode = apbReq.pwdata[PC_MODE_LSB +: MODE_W];
               next_state.en = apbReq.pwdata[PC_EN_BIT];
               next_state.pol = apbReq.pwdata[PC_POL_BIT];
               next_state.pres = apbReq.pwdata[PC_PRES_LSB +: PRES_W];
            end
            ADDR_SCTRL: begin
               next_state.outEnable = apbReq.pwdata[SC_OUTEN_BIT];
               next_state.invOutEnable = apbReq.pwdata[SC_INVEN_BIT];
               next_state.irqEnable = apbReq.pwdata[SC_IRQEN_BIT];
               next_state.wakeEnable = apbReq.pwdata[SC_WAKEEN_BIT];
               next_state.clkEnable = apbReq.pwdata[SC_CLKEN_BIT];
            end
            ADDR_IRQFL: clearIrq = apbReq.pwdata[FL_FLAG_BIT];
            ADDR_WAKEFL: clearWake = apbReq.pwdata[FL_FLAG_BIT];
            ADDR_LPWAKE: begin
               clearLp = apbReq.pwdata[FL_FLAG_BIT];
               next_state.lpWakeEnable = apbReq.pwdata[LP_ENABLE_BIT];
            end
            default: next_state.prdata = state.prdata;
         endcase
      end
      // Ready follows the enable one cycle late, standing in for the source-clock handshake
      next_state.clkReady = state.clkEnable;
      next_state.pinInput = inputMode && (IS_LP ? pinIn.pinBSignal : pinIn.pinASignal);
      // Flags: an event in the clearing cycle wins over the clear
      next_state.irqFlag = (state.irqFlag && !clearIrq) || periodEnd;
      next_state.wakeFlag = (state.wakeFlag && !clearWake) || (periodEnd && state.wakeEnable);
      next_state.lpWakeStatus = (state.lpWakeStatus && !clearLp) || (IS_LP && periodEnd);
      if (tick) begin
         next_state.pulse = 1'b0;
      end
      if (tick && running) begin
         if (periodEnd) begin
            // Hardware wins over a same-cycle software write of count or enable
            next_state.count = COUNT_RELOAD;
            next_state.en = 1'b0;
            next_state.pulse = 1'b1;
         end else begin
            next_state.count = state.count + COUNT_RELOAD;
         end
      end
      next_state.timerOut = next_state.pol ^ next_state.pulse;
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         state <= '0;
         state.count <= COUNT_RESET;
         state.compare <= COMPARE_RESET;
         state.pres <= PRES_RESET;
      end else begin
         state <= next_state;
      end
   end

   // Pin drive: TimerA on pin A for full timers, on pin B for low-power ones
   always_comb begin
      logic drivePrimary;
      drivePrimary = outputMode && state.outEnable;
      pinOut = '0;
      if (IS_LP) begin
         pinOut.pinBSignal = state.timerOut;
         pinOut.pinBOe = drivePrimary;
      end else begin
         pinOut.pinASignal = state.timerOut;
         pinOut.pinAOe = drivePrimary;
         // TimerB is not counted here; its pin idles at the inactive level
         pinOut.pinBSignal = state.pol;
         pinOut.pinBOe = drivePrimary;
         if (HAS_COMP) begin
            pinOut.pinAInvertedSignal = ~state.timerOut;
            pinOut.pinAInvertedOe = outputMode && state.invOutEnable;
            pinOut.pinBInvertedSignal = ~state.pol;
            pinOut.pinBInvertedOe = outputMode && state.invOutEnable;
         end
      end
   end

   assign wakeClockRequest = IS_LP && sysClockStopped && state.wakeEnable && state.lpWakeEnable &&
                             state.lpWakeStatus;

   assign apbRsp.prdata = state.prdata;
   assign apbRsp.pready = 1'b1;
   assign apbRsp.pslverr = apbReq.psel && apbReq.penable && !mapped;

   sequence endSeq;
      tick && running && (state.count == state.compare);
   endsequence

   sequence stepSeq;
      tick && running && (state.count != state.compare);
   endsequence

   oneshot_reload_a: assert property (@(posedge clk) disable iff (reset)
      endSeq |=> (state.count == 32'h00000001) && !state.en)
      else $error("one-shot end did not reload");
   irq_set_a: assert property (@(posedge clk) disable iff (reset)
      endSeq |=> state.irqFlag)
      else $error("period end did not set irq");
   pulse_once_a: assert property (@(posedge clk) disable iff (reset)
      endSeq |=> state.pulse && (state.timerOut != state.pol))
      else $error("output pulse missing");
   pulse_hold_a: assert property (@(posedge clk) disable iff (reset)
      (state.pulse && !tick) |=> state.pulse)
      else $error("pulse dropped between ticks");
   pulse_drop_a: assert property (@(posedge clk) disable iff (reset)
      (state.pulse && tick && !periodEnd) |=> !state.pulse)
      else $error("pulse longer than one tick");
   out_level_a: assert property (@(posedge clk) disable iff (reset)
      state.timerOut == (state.pol ^ state.pulse))
      else $error("output level not polarity and pulse");
   count_step_a: assert property (@(posedge clk) disable iff (reset)
      stepSeq |=> state.count == $past(state.count) + 32'h00000001)
      else $error("count did not step");
   count_hold_a: assert property (@(posedge clk) disable iff (reset)
      (!tick && !writeAccess) |=> $stable(state.count))
      else $error("count moved without tick");
   enable_off_a: assert property (@(posedge clk) disable iff (reset)
      (!state.en && !writeAccess) |=> !state.en)
      else $error("timer enabled itself");
   reset_count_a: assert property (@(posedge clk)
      reset |=> state.count == 32'h00000000)
      else $error("reset left count nonzero");
   out_dir_a: assert property (@(posedge clk) disable iff (reset)
      (pinOut.pinAOe || pinOut.pinBOe) |-> outputMode)
      else $error("pin driven outside output mode");
   in_dir_a: assert property (@(posedge clk) disable iff (reset)
      inputMode |-> !pinOut.pinAOe && !pinOut.pinBOe)
      else $error("pin driven in input mode");
   mode_excl_a: assert property (@(posedge clk) disable iff (reset)
      !(outputMode && inputMode))
      else $error("pin both input and output");
   reserved_mode_a: assert property (@(posedge clk) disable iff (reset)
      ((state.mode > MODE_DUALEDGE) && (state.mode != MODE_INACTGATED)) |-> !outputMode && !inputMode)
      else $error("reserved mode uses the pin");
   inv_pin_a: assert property (@(posedge clk) disable iff (reset)
      pinOut.pinAInvertedOe |-> pinOut.pinAInvertedSignal == !pinOut.pinASignal)
      else $error("complement not inverse");
   inv_b_pin_a: assert property (@(posedge clk) disable iff (reset)
      pinOut.pinBInvertedOe |-> pinOut.pinBInvertedSignal == !pinOut.pinBSignal)
      else $error("B complement not inverse");
   lp_pins_a: assert property (@(posedge clk) disable iff (reset)
      IS_LP |-> !pinOut.pinAOe && !pinOut.pinAInvertedOe && !pinOut.pinBInvertedOe)
      else $error("low-power timer drives a pin it lacks");
   wake_gate_a: assert property (@(posedge clk) disable iff (reset)
      (endSeq ##0 !state.wakeEnable ##1 !$past(state.wakeFlag)) |-> !state.wakeFlag)
      else $error("wake flag set while disabled");
   wake_set_a: assert property (@(posedge clk) disable iff (reset)
      (endSeq ##0 state.wakeEnable) |=> state.wakeFlag)
      else $error("wake flag not set");
   wake_req_a: assert property (@(posedge clk) disable iff (reset)
      wakeClockRequest |-> IS_LP && state.wakeEnable && state.lpWakeStatus)
      else $error("wake request without enabled event");
   lp_status_a: assert property (@(posedge clk) disable iff (reset)
      (endSeq ##0 IS_LP) |=> state.lpWakeStatus)
      else $error("low-power status not set");
endmodule : tmpow_timer

/* verification/tmpow_pin_partner.sv */
// External side of the timer pins: a source that drives the pin while the timer does not.
// Assumes the timer's output enables are high whenever it drives a pin.
`timescale 1ns/10ps
module tmpow_pin_partner
   import tmpow_pkg::*;
(
   // Timer side
   input wire tmpow_pin_out_t pinOut,
   // Level the external source offers
   input wire logic extLevel,
   // Resolved wire levels
   output tmpow_pin_in_t pinIn
);
   // The source backs off while the timer drives, so no fight on the wire
   assign pinIn.pinASignal = pinOut.pinAOe ? pinOut.pinASignal : extLevel;
   assign pinIn.pinBSignal = pinOut.pinBOe ? pinOut.pinBSignal : extLevel;
endmodule : tmpow_pin_partner

/* verification/tmpow_timer_test.sv */
// Self-checking bench: a full timer with complement and a low-power timer share one APB master.
// Assumes zero or more wait states, pins resolved by the partner model.
`timescale 1ns/10ps
module tmpow_timer_test
   import tmpow_pkg::*;
;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic sysClockStopped = 1'b0;
   logic extLevel = 1'b0;
   tmpow_apb_req_t req = '0;
   wire tmpow_apb_rsp_t rsp [2];
   wire tmpow_pin_in_t pinIn [2];
   wire tmpow_pin_out_t pinOut [2];
   wire logic [1:0] wakeReq;
   logic [31:0] rd, r, startCount;
   logic err;
   int n_fail = 0;
   int check_count = 0;
   int seed = 32'hb9a0;

   always #5 clk = ~clk;

   for (genvar g = 0; g < 2; g++) begin : gen_inst
      tmpow_timer #(.INSTANCE_KIND(g == 0 ? KIND_FULL_COMP : KIND_LOWPOWER)) i_tmpow_timer (
         .clk(clk), .reset(reset), .apbReq(req), .apbRsp(rsp[g]), .pinIn(pinIn[g]), .pinOut(pinOut[g]),
         .sysClockStopped(sysClockStopped), .wakeClockRequest(wakeReq[g]));
      tmpow_pin_partner i_tmpow_pin_partner (.pinOut(pinOut[g]), .extLevel(extLevel), .pinIn(pinIn[g]));
   end

   task automatic end_of_test;
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : end_of_test

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // Both slaves see the same request; s picks whose answer is taken
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input int s);
      @(posedge clk);
      req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
      @(posedge clk);
      req.penable <= 1'b1;
      do @(posedge clk); while (rsp[s].pready !== 1'b1);
      rd = rsp[s].prdata;
      err = rsp[s].pslverr;
      req <= '0;
   endtask : apb

   task automatic rdchk(input int s, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string w);
      apb(1'b0, a, 32'h0, s);
      chk(w, e, rd & m);
   endtask : rdchk

   function automatic logic outMode(input logic [3:0] m);
      return m inside {4'h0, 4'h1, 4'h3, 4'h5};
   endfunction : outMode

   function automatic logic inMode(input logic [3:0] m);
      return m inside {4'h2, 4'h4, 4'h6, 4'h7, 4'h8, 4'he};
   endfunction : inMode

   task automatic oneShot(input logic setInit, input logic [31:0] init, input logic [31:0] cmp,
                          input logic [11:0] pres, input logic pol, input logic wake);
      int t, lo, hi, width;
      if (setInit) startCount = init;
      // Prescaler phase is free-running, so the first tick lands anywhere in one divide span
      lo = (cmp - startCount) * (pres + 1) + 2;
      hi = (cmp - startCount + 1) * (pres + 1) + 1;
      apb(1'b1, ADDR_PCTRL, 32'h0, 0);
      apb(1'b1, ADDR_SCTRL, {27'h0, 1'b1, wake, 3'b111}, 0);
      t = 0;
      do begin
         apb(1'b0, ADDR_SCTRL, 32'h0, 1);
         t++;
      end while (rd[SC_CLKRDY_BIT] !== 1'b1 && t < 20);
      apb(1'b1, ADDR_LPWAKE, 32'h2, 0);
      apb(1'b1, ADDR_COMPARE, cmp, 0);
      if (setInit) apb(1'b1, ADDR_COUNT, init, 0);
      apb(1'b1, ADDR_PCTRL, {4'h0, pres, 10'h0, pol, 5'h00}, 0);
      apb(1'b1, ADDR_PCTRL, {4'h0, pres, 10'h0, pol, 5'h10}, 0);
      t = 0;
      while (pinOut[0].pinASignal === pol && t < hi + 5) begin
         @(negedge clk);
         t++;
      end
      chk("period in range", 32'h1, (t >= lo && t <= hi));
      chk("inverted pin", pol, pinOut[0].pinAInvertedSignal);
      chk("inverted pin B", !pol, pinOut[0].pinBInvertedSignal);
      chk("lp pin B pulse", !pol, pinOut[1].pinBSignal);
      width = 0;
      while (pinOut[0].pinASignal === ~pol && width < 5000) begin
         @(negedge clk);
         width++;
      end
      chk("pulse width", pres + 1, width);
      rdchk(0, ADDR_COUNT, '1, COUNT_RELOAD, "reload count");
      rdchk(0, ADDR_PCTRL, 32'h10, 32'h0, "enable cleared");
      rdchk(0, ADDR_IRQFL, 32'h1, 32'h1, "irq flag");
      rdchk(1, ADDR_WAKEFL, 32'h1, wake, "wake flag");
      rdchk(1, ADDR_LPWAKE, 32'h1, 32'h1, "lp wake status");
      rdchk(1, ADDR_IRQFL, 32'h1, 32'h1, "lp irq flag");
      sysClockStopped <= 1'b1;
      @(negedge clk);
      chk("wake request", {wake, 1'b0}, wakeReq);
      @(posedge clk);
      sysClockStopped <= 1'b0;
      apb(1'b1, ADDR_IRQFL, 32'h1, 0);
      apb(1'b1, ADDR_WAKEFL, 32'h1, 0);
      apb(1'b1, ADDR_LPWAKE, 32'h3, 0);
      rdchk(1, ADDR_IRQFL, 32'h1, 32'h0, "irq cleared");
      startCount = COUNT_RELOAD;
      $display("one-shot compare %h prescale %0d done", cmp, pres);
   endtask : oneShot

   initial begin
      #500000;
      n_fail++;
      end_of_test();
   end

   initial begin
      startCount = COUNT_RESET;
      repeat (5) @(posedge clk);
      reset <= 1'b0;
      rdchk(0, ADDR_COUNT, '1, COUNT_RESET, "reset count");
      rdchk(0, ADDR_COMPARE, '1, COMPARE_RESET, "reset compare");
      chk("reset pin enable", 32'h0, pinOut[0].pinAOe);
      apb(1'b0, 8'h1c, 32'h0, 0);
      chk("unmapped data", 32'h0, rd);
      chk("unmapped error", 32'h1, err);
      $display("reset and map test done");
      for (int m = 0; m < 16; m++) begin
         r = $random(seed);
         extLevel <= r[0];
         apb(1'b1, ADDR_SCTRL, 32'h13, 0);
         apb(1'b1, ADDR_PCTRL, m, 0);
         @(negedge clk);
         chk("pin A enable", outMode(4'(m)), pinOut[0].pinAOe);
         chk("inverted enable", outMode(4'(m)), pinOut[0].pinAInvertedOe);
         chk("inverted B enable", outMode(4'(m)), pinOut[0].pinBInvertedOe);
         chk("lp no complement", 32'h0, pinOut[1].pinAInvertedOe);
         chk("lp pin B enable", outMode(4'(m)), pinOut[1].pinBOe);
         if (inMode(4'(m))) begin
            rdchk(0, ADDR_SCTRL, 32'h40, {25'h0, r[0], 6'h0}, "pin A input");
            rdchk(1, ADDR_SCTRL, 32'h40, {25'h0, r[0], 6'h0}, "lp pin B input");
         end
      end
      $display("mode pin test done");
      oneShot(1'b0, 32'h0, 32'h5, 12'h0, 1'b0, 1'b1);
      oneShot(1'b0, 32'h0, 32'h3, 12'h2, 1'b1, 1'b0);
      oneShot(1'b1, 32'h7, 32'h7, 12'h0, 1'b0, 1'b1);
      for (int i = 0; i < 5; i++) begin
         r = $random(seed);
         oneShot(1'b1, r[1:0] + 1, r[1:0] + 1 + r[7:4], {10'h0, r[9:8]}, r[12], r[13]);
      end
      end_of_test();
   end
endmodule : tmpow_timer_test
